// File: ebpc_top.sv
// External bus pin control: drive, float and holder logic
`timescale 1ns/1ns
// Overview of operation
// - The address bus is 23 bits wide, bit 22 most significant.
// - The low sixteen address lines carry every external access.
// - The upper seven lines carry address bits only for program accesses.
// - In hold mode all address lines float.
// - A low emulation float input floats every address line.
// - A holder keeps each floating address line at its last level, except the upper seven, which go to zero during non-program accesses.
// - The data bus is 16 bits wide, bidirectional, bit 15 most significant.
// - Data is driven only while writing; it floats in reset or hold.
// - A low emulation float input floats every data line.
// - A holder keeps each floating data line at its last level.
// - Software can switch the data holder on or off.
// - Space selects idle high, one low only during its valid access.
module ebpc_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic device_reset_n,
  input wire logic emulation_float_n,
  input wire logic hold_req_n,
  input wire ebpc_pkg::ebpc_req_t core_req,
  output logic core_ack,
  output logic [15:0] core_rdata,
  input wire logic [22:0] ext_address_in,
  output logic [22:0] ext_address_out,
  output logic [22:0] ext_address_oe,
  input wire logic [15:0] ext_data_in,
  output logic [15:0] ext_data_out,
  output logic [15:0] ext_data_oe,
  output logic data_space_sel_n,
  output logic program_space_sel_n,
  output logic io_space_sel_n,
  output logic space_sel_oe,
  output logic bus_hold_grant,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import ebpc_pkg::*;

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic [15:0] din_s1_reg;
  logic [15:0] din_s2_reg;
  logic [22:0] ain_s1_reg;
  logic [22:0] ain_s2_reg;
  wire rst_pin = ~pin_s2_reg[0];
  wire float_pin = ~pin_s2_reg[1];
  wire hold_pin = ~pin_s2_reg[2];

  // Two stages before any logic looks at a pin
  always_ff @(posedge sys_clk) begin
    pin_s1_reg <= {~hold_req_n, emulation_float_n, device_reset_n} ^ 3'h4;
    pin_s2_reg <= pin_s1_reg;
    din_s1_reg <= ext_data_in;
    din_s2_reg <= din_s1_reg;
    ain_s1_reg <= ext_address_in;
    ain_s2_reg <= ain_s1_reg;
  end

  // --------------------------------------------------------------------
  // Access sequencer
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR = 4'h2,
    ST_DATA = 4'h4,
    ST_HOLD = 4'h8
  } ebpc_state_t;
  ebpc_state_t state_reg, state_next;
  ebpc_req_t req_reg, req_next;
  wire in_reset = srst | rst_pin;

  // Data phase counter; a shorter phase would sample stale read data
  logic [1:0] data_cnt_reg;
  wire in_data = state_reg == ST_DATA;
  wire data_last = in_data & (data_cnt_reg == EBPC_DATA_LAST);
  wire [1:0] data_cnt_next = in_data ? data_cnt_reg + 2'h1 : 2'h0;

  // Hold is only taken from idle, so an access always finishes first
  always_comb begin
    state_next = state_reg;
    req_next = req_reg;
    case (state_reg)
      ST_IDLE: begin
        if (hold_pin) begin
          state_next = ST_HOLD;
        end else if (core_req.valid) begin
          req_next = core_req;
          state_next = ST_ADDR;
        end
      end
      ST_ADDR: state_next = ST_DATA;
      ST_DATA: state_next = data_last ? ST_IDLE : ST_DATA;
      ST_HOLD: begin
        if (!hold_pin) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (in_reset) begin
      state_reg <= ST_IDLE;
      req_reg <= '0;
      data_cnt_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
      data_cnt_reg <= data_cnt_next;
    end
  end

  // --------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------
  logic holder_en_reg;
  wire wr_ctrl = reg_wr & (reg_addr == EBPC_CTRL_OFS);
  wire rd_ctrl = reg_rd & (reg_addr == EBPC_CTRL_OFS);
  wire rd_stat = reg_rd & (reg_addr == EBPC_STAT_OFS);
  wire [31:0] stat_word = {27'h0, float_pin, hold_pin,
                           state_reg == ST_HOLD, state_reg == ST_DATA,
                           state_reg == ST_ADDR};

  // Holder switch is software owned; unmapped reads return zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      holder_en_reg <= EBPC_CTRL_RST[EBPC_CTRL_HOLDER_BIT];
      reg_rdata <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        holder_en_reg <= reg_wdata[EBPC_CTRL_HOLDER_BIT];
      end
      reg_rdata <= rd_ctrl ? {31'h0, holder_en_reg} :
                   rd_stat ? stat_word : 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------
  // Pin drive decode
  // --------------------------------------------------------------------
  wire active = (state_reg == ST_ADDR) | (state_reg == ST_DATA);
  wire prog_acc = req_reg.space == EBPC_SP_PROG;
  wire a_lo_drv = active & ~float_pin & ~in_reset;
  wire a_hi_drv = a_lo_drv & prog_acc;
  wire d_drv = (state_reg == ST_DATA) & req_reg.write & ~float_pin &
               ~in_reset & ~hold_pin;
  // Only program accesses carry the upper bits; others keep them zero
  wire [6:0] a_hi_val = prog_acc ? req_reg.addr[22:16] : 7'h00;
  wire [22:0] a_val = {a_hi_val, req_reg.addr[15:0]};
  wire sel_drv = ~float_pin & (state_reg != ST_HOLD);
  wire [15:0] d_hold = holder_en_reg ? din_s2_reg : ext_data_out;

  // Outputs held in flip-flops; while floating the out value tracks the
  // wire (data only while the holder switch is on, else it keeps its value), except the upper address bits, which are zero in non-program accesses,
  // so that a keeper built from it restores the last level
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ext_address_out <= '0;
      ext_address_oe <= '0;
      ext_data_out <= '0;
      ext_data_oe <= '0;
      data_space_sel_n <= 1'b1;
      program_space_sel_n <= 1'b1;
      io_space_sel_n <= 1'b1;
      space_sel_oe <= 1'b0;
      bus_hold_grant <= 1'b0;
      core_ack <= 1'b0;
      core_rdata <= '0;
    end else begin
      ext_address_out <= a_lo_drv ? a_val : ain_s2_reg;
      ext_address_oe <= {{7{a_hi_drv}}, {16{a_lo_drv}}};
      ext_data_out <= d_drv ? req_reg.wdata : d_hold;
      ext_data_oe <= holder_en_reg | d_drv ? {16{d_drv}} : 16'h0000;
      data_space_sel_n <= ~(active & (req_reg.space == EBPC_SP_DATA));
      program_space_sel_n <= ~(active & prog_acc);
      io_space_sel_n <= ~(active & (req_reg.space == EBPC_SP_IO));
      space_sel_oe <= sel_drv;
      bus_hold_grant <= (state_next == ST_HOLD) & ~in_reset;
      core_ack <= data_last & ~in_reset;
      core_rdata <= (data_last & ~req_reg.write) ?
                    din_s2_reg : core_rdata;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  sequence s_access;
    state_reg == ST_ADDR ##1 state_reg == ST_DATA [*3];
  endsequence
  property p_hold_float;
    @(posedge sys_clk) disable iff (srst)
      state_reg == ST_HOLD |=> ext_address_oe == 23'h0;
  endproperty
  a_hold_float: assert property (p_hold_float)
    else $error("addr driven in hold");
  property p_off_float;
    @(posedge sys_clk) disable iff (srst)
      float_pin |=> (ext_address_oe == 23'h0) && (ext_data_oe == 16'h0);
  endproperty
  a_off_float: assert property (p_off_float)
    else $error("bus driven while off");
  property p_hi_prog;
    @(posedge sys_clk) disable iff (srst)
      ext_address_oe[22] |-> !program_space_sel_n;
  endproperty
  a_hi_prog: assert property (p_hi_prog)
    else $error("upper addr not prog");
  property p_data_write;
    @(posedge sys_clk) disable iff (srst)
      ext_data_oe[0] |-> $past(state_reg == ST_DATA && req_reg.write);
  endproperty
  a_data_write: assert property (p_data_write)
    else $error("data driven no write");
  property p_grant_idle;
    @(posedge sys_clk) disable iff (srst)
      $rose(bus_hold_grant) |-> $past(state_reg) == ST_IDLE;
  endproperty
  a_grant_idle: assert property (p_grant_idle)
    else $error("grant mid access");
  property p_sel_one;
    @(posedge sys_clk) disable iff (srst)
      $countones({data_space_sel_n, program_space_sel_n,
                  io_space_sel_n}) >= 2;
  endproperty
  a_sel_one: assert property (p_sel_one)
    else $error("two selects low");
  property p_access_len;
    @(posedge sys_clk) disable iff (srst || in_reset)
      (state_reg == ST_IDLE && !hold_pin && core_req.valid) |=>
        s_access ##1 core_ack;
  endproperty
  a_access_len: assert property (p_access_len)
    else $error("access length");
  property p_holder_off;
    @(posedge sys_clk) disable iff (srst)
      !holder_en_reg && !d_drv |=> ext_data_oe == 16'h0;
  endproperty
  a_holder_off: assert property (p_holder_off)
    else $error("holder off");

  // --------------------------------------------------------------------
  // Assertions: float conditions and driven values
  // --------------------------------------------------------------------
  property p_sel_float;
    @(posedge sys_clk) disable iff (srst)
      float_pin |=> !space_sel_oe;
  endproperty
  a_sel_float: assert property (p_sel_float)
    else $error("selects driven while off");
  property p_reset_float;
    @(posedge sys_clk) disable iff (srst)
      in_reset |=> (ext_address_oe == 23'h0) && (ext_data_oe == 16'h0);
  endproperty
  a_reset_float: assert property (p_reset_float)
    else $error("bus driven in reset");
  property p_hold_data_float;
    @(posedge sys_clk) disable iff (srst)
      hold_pin |=> ext_data_oe == 16'h0;
  endproperty
  a_hold_data_float: assert property (p_hold_data_float)
    else $error("data driven with hold request");
  // Driven values must be the accepted request, never a stale word
  property p_write_value;
    @(posedge sys_clk) disable iff (srst)
      ext_data_oe[0] |-> ext_data_out == req_reg.wdata;
  endproperty
  a_write_value: assert property (p_write_value)
    else $error("wrong write data");
  property p_addr_value;
    @(posedge sys_clk) disable iff (srst)
      ext_address_oe[0] |-> ext_address_out[15:0] == req_reg.addr[15:0];
  endproperty
  a_addr_value: assert property (p_addr_value)
    else $error("wrong address");
  property p_addr_lo_whole;
    @(posedge sys_clk) disable iff (srst)
      (ext_address_oe[15:0] == 16'h0) || (ext_address_oe[15:0] == 16'hFFFF);
  endproperty
  a_addr_lo_whole: assert property (p_addr_lo_whole)
    else $error("low address lines split");
  property p_ack_pulse;
    @(posedge sys_clk) disable iff (srst)
      core_ack |=> !core_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");

  // --------------------------------------------------------------------
  // Assertions: hold handshake and register port
  // --------------------------------------------------------------------
  property p_grant_state;
    @(posedge sys_clk) disable iff (srst)
      bus_hold_grant == (state_reg == ST_HOLD);
  endproperty
  a_grant_state: assert property (p_grant_state)
    else $error("grant not matching hold state");
  property p_hold_exit;
    @(posedge sys_clk) disable iff (srst)
      (state_reg == ST_HOLD) && !hold_pin |=> state_reg == ST_IDLE;
  endproperty
  a_hold_exit: assert property (p_hold_exit)
    else $error("hold not left");
  property p_rdata_idle;
    @(posedge sys_clk) disable iff (srst)
      !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data without read");
  property p_ctrl_write;
    @(posedge sys_clk) disable iff (srst)
      wr_ctrl |=> holder_en_reg == $past(reg_wdata[EBPC_CTRL_HOLDER_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("holder switch not written");
endmodule

// File: ebpc_pkg.sv
// Package for the external bus pin control block
package ebpc_pkg;
  // --------------------------------------------------------------------
  // Widths
  // --------------------------------------------------------------------
  localparam int EBPC_AW = 23;
  localparam int EBPC_LOW_AW = 16;
  localparam int EBPC_DW = 16;
  // --------------------------------------------------------------------
  // Register map (word index on the plain register port)
  // --------------------------------------------------------------------
  localparam logic [3:0] EBPC_CTRL_OFS = 4'h0;
  localparam logic [3:0] EBPC_STAT_OFS = 4'h1;
  localparam int EBPC_CTRL_HOLDER_BIT = 0;
  localparam logic [31:0] EBPC_CTRL_RST = 32'h0000_0001;
  // Last count of the data phase; three cycles let read data pass two stages
  localparam logic [1:0] EBPC_DATA_LAST = 2'h2;
  // Access spaces
  typedef enum logic [1:0] {
    EBPC_SP_PROG = 2'h0,
    EBPC_SP_DATA = 2'h1,
    EBPC_SP_IO = 2'h2
  } ebpc_space_t;
  // Core access request
  typedef struct packed {
    logic valid;
    logic write;
    ebpc_space_t space;
    logic [22:0] addr;
    logic [15:0] wdata;
  } ebpc_req_t;
  // Pin group for one bus
  typedef struct packed {
    logic [22:0] a_out;
    logic [22:0] a_oe;
    logic [15:0] d_out;
    logic [15:0] d_oe;
  } ebpc_pins_t;
endpackage

// File: ebpc_ext_mem.sv
// Behavioural model of the external memory and I/O devices on the bus
`timescale 1ns/1ns
module ebpc_ext_mem (
  input wire logic sys_clk,
  input wire logic [22:0] addr,
  input wire logic [15:0] data,
  input wire logic [15:0] data_oe,
  input wire logic [2:0] sel_n,
  output logic drive_en,
  output logic [15:0] drive_data
);
  logic [15:0] mem_reg [0:63];
  logic [1:0] space;
  // --------------------------------------------------------------------
  // Decode and reply
  // --------------------------------------------------------------------
  // Select order is data, program, io; one space per access
  assign space = !sel_n[2] ? 2'h0 : (!sel_n[1] ? 2'h1 : 2'h2);
  // Reply only while selected and the device has let go of the data lines
  assign drive_en = (sel_n != 3'h7) && (data_oe == 16'h0000);
  assign drive_data = mem_reg[{space, addr[3:0]}];
  // Store what the device drives; small array, so addresses alias by 16
  always_ff @(posedge sys_clk) begin
    if (sel_n != 3'h7 && data_oe == 16'hFFFF) begin
      mem_reg[{space, addr[3:0]}] <= data;
    end
  end
endmodule

// File: ebpc_top_tb_top.sv
// Self-checking testbench for the external bus pin control block
`timescale 1ns/1ns
module ebpc_top_tb_top;
  import ebpc_pkg::*;
  logic sys_clk = 0, srst = 1, device_reset_n = 1, emulation_float_n = 1;
  logic hold_req_n = 1, core_ack, space_sel_oe, bus_hold_grant;
  logic reg_wr = 0, reg_rd = 0, holder_on = 1, drv_en;
  logic ds_n, ps_n, is_n;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  ebpc_req_t core_req = '0;
  logic [15:0] core_rdata, d_out, d_oe, d_wire, d_last = 16'h0, drv_d;
  logic [22:0] a_out, a_oe;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  // --------------------------------------------------------------------
  // Clock, pin resolution and timeout
  // --------------------------------------------------------------------
  always #5 sys_clk = ~sys_clk;
  // Released lines keep the holder level, or wander when it is off
  assign d_wire = (d_oe & d_out) | (~d_oe & (drv_en ? drv_d :
                  (holder_on ? d_last : ~d_last)));
  always @(posedge sys_clk) begin
    d_last <= d_wire;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  ebpc_top ebpc_top_i (.sys_clk(sys_clk), .srst(srst),
    .device_reset_n(device_reset_n), .emulation_float_n(emulation_float_n),
    .hold_req_n(hold_req_n), .core_req(core_req), .core_ack(core_ack),
    .core_rdata(core_rdata), .ext_address_in(a_out),
    .ext_address_out(a_out), .ext_address_oe(a_oe), .ext_data_in(d_wire),
    .ext_data_out(d_out), .ext_data_oe(d_oe), .data_space_sel_n(ds_n),
    .program_space_sel_n(ps_n), .io_space_sel_n(is_n),
    .space_sel_oe(space_sel_oe), .bus_hold_grant(bus_hold_grant),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  ebpc_ext_mem ebpc_ext_mem_i (.sys_clk(sys_clk), .addr(a_out),
    .data(d_wire), .data_oe(d_oe), .sel_n({ds_n, ps_n, is_n}),
    .drive_en(drv_en), .drive_data(drv_d));
  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask
  task automatic reg_check(input logic [3:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 0;
    #1 chk(reg_rdata, exp);
  endtask
  // One access; checks address drive, selects and read data
  task automatic access(input ebpc_space_t sp, input logic wr,
                        input logic [22:0] a, input logic [15:0] d);
    logic [31:0] exp_sel;
    int n_wait;
    exp_sel = (sp == EBPC_SP_PROG) ? 32'h5 :
              (sp == EBPC_SP_DATA) ? 32'h3 : 32'h6;
    n_wait = 0;
    @(posedge sys_clk);
    core_req <= '{1'b1, wr, sp, a, d};
    @(posedge sys_clk);
    core_req.valid <= 0;
    // Pins follow the address phase by one registered edge
    @(posedge sys_clk);
    #1 chk(a_oe, (sp == EBPC_SP_PROG) ? 32'h7FFFFF : 32'h00FFFF);
    chk(a_out, (sp == EBPC_SP_PROG) ? a : {7'h00, a[15:0]});
    chk({ds_n, ps_n, is_n}, exp_sel);
    while (n_wait < 8 && core_ack !== 1'b1) begin
      @(posedge sys_clk) #1;
      n_wait++;
    end
    chk(n_wait, EBPC_DATA_LAST + 1);
    chk(core_ack, 1);
    if (!wr) chk(core_rdata, d);
    repeat (3) @(posedge sys_clk);
    #1 chk(a_out, (sp == EBPC_SP_PROG) ? a : {7'h00, a[15:0]});
    chk(d_oe, 0);
    if (wr) chk(d_out, d);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 0;
    #1 chk(a_oe, 0);
    chk(d_oe, 0);
    chk({ds_n, ps_n, is_n, bus_hold_grant}, 4'hE);
    reg_check(EBPC_CTRL_OFS, EBPC_CTRL_RST);
    reg_write(EBPC_CTRL_OFS, 32'h0);
    reg_check(EBPC_CTRL_OFS, 32'h0);
    reg_write(EBPC_CTRL_OFS, 32'h1);
    reg_check(4'hF, 32'h0);
    for (int s = 0; s < 3; s++) begin
      access(ebpc_space_t'(s), 1, 23'h5A_C3A0 + s, 16'hA5C0 + s);
      access(ebpc_space_t'(s), 0, 23'h5A_C3A0 + s, 16'hA5C0 + s);
    end
    // Hold is requested in the same cycle as an access
    @(posedge sys_clk);
    core_req <= '{1'b1, 1'b1, EBPC_SP_DATA, 23'h000009, 16'h3C3C};
    hold_req_n <= 0;
    @(posedge sys_clk);
    core_req.valid <= 0;
    for (int i = 0; i < 12 && bus_hold_grant !== 1'b1; i++)
      @(posedge sys_clk) #1;
    chk(core_ack, 0);
    chk(bus_hold_grant, 1);
    chk(a_oe, 0);
    chk(d_oe, 0);
    @(posedge sys_clk);
    hold_req_n <= 1;
    // The release passes two pin stages before hold is left
    repeat (4) @(posedge sys_clk);
    #1 chk(bus_hold_grant, 0);
    // The write made while hold was pending drove no data on the bus, so write it again
    access(EBPC_SP_DATA, 1, 23'h000009, 16'h3C3C);
    access(EBPC_SP_DATA, 0, 23'h000009, 16'h3C3C);
    emulation_float_n <= 0;
    repeat (4) @(posedge sys_clk);
    #1 chk(a_oe, 0);
    chk({d_oe, space_sel_oe}, 0);
    emulation_float_n <= 1;
    device_reset_n <= 0;
    repeat (4) @(posedge sys_clk);
    #1 chk(d_oe, 0);
    device_reset_n <= 1;
    repeat (3) @(posedge sys_clk);
    give_verdict();
  end
endmodule
